// >>> bench/lbc_prog_mem.sv
// program memory model holding instruction words
`timescale 1ns/100ps
module lbc_prog_mem (
  input wire logic [15:0] addr_in,
  output logic [15:0] word_out
);
  logic [15:0] mem [0:65535];
  assign word_out = mem[addr_in];
endmodule // lbc_prog_mem

// >>> bench/lbc_unit_properties.sv
// port checker for the long branch and call unit
`timescale 1ns/100ps
module lbc_unit_properties (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_word_in,
  input wire logic [15:0] fetch_addr_out,
  input wire logic [4:0] tested_register_field_out,
  input wire logic [7:0] reg_data_in,
  input wire logic [1:0] index_register_operand_out,
  input wire logic [15:0] index_data_in,
  input wire logic push_out,
  input wire lbc_pkg::lbc_frame_t push_frame_out,
  input wire logic [15:0] pc_out,
  input wire logic flags_write_out
);
  logic op2_q;
  wire logic op = instr_valid_in && !op2_q;
  wire logic call = op && instr_word_in == 16'h8800;
  // op2_q marks the operand slot of a two-word op
  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in) op2_q <= 1'b0;
    else if (instr_valid_in) op2_q <= op && (instr_word_in[15:1] == 15'h4400 || instr_word_in[15:9] == 7'h26);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_call; call ##1 instr_valid_in; endsequence
  sequence s_jabs; op && instr_word_in == 16'h8801 ##1 instr_valid_in; endsequence
  sequence s_jc; op && instr_word_in[15:9] == 7'h26 ##1 instr_valid_in; endsequence
  AST_PUSH: assert property (call |=> push_out && push_frame_out.pc == $past(fetch_addr_out) + 16'h2)
    else $error("call push wrong");
  AST_PULSE: assert property (push_out |-> $past(call))
    else $error("stray push");
  AST_CALL: assert property (s_call |=> pc_out == $past(instr_word_in))
    else $error("call target wrong");
  AST_JABS: assert property (s_jabs |=> pc_out == $past(instr_word_in))
    else $error("jump target wrong");
  AST_JC: assert property (s_jc |=> pc_out == ($past(reg_data_in[instr_word_in[7:5]] == instr_word_in[8], 2) ? $past(instr_word_in) : $past(fetch_addr_out) + 16'h1))
    else $error("conditional jump wrong");
  AST_JIDX: assert property (op && instr_word_in[15:2] == 14'h2201 |=> pc_out == $past(index_data_in))
    else $error("indexed jump wrong");
  AST_SEL: assert property (instr_valid_in |-> tested_register_field_out == instr_word_in[4:0])
    else $error("register select wrong");
  AST_IDX: assert property (instr_valid_in |-> index_register_operand_out == instr_word_in[1:0])
    else $error("index register select wrong");
  AST_FLAGS: assert property (!flags_write_out)
    else $error("flags written");
endmodule // lbc_unit_properties
bind lbc_unit lbc_unit_properties chk (.*);

// >>> bench/tb_top.sv
// self-checking bench for the long branch and call unit
`timescale 1ns/100ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin errors++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb_top;
  logic clock_in = 1'b0, rst_n_in = 1'b0, instr_valid_in = 1'b0, global_interrupt_enable_in = 1'b0;
  logic [15:0] instr_word_in, fetch_addr_out, index_data_in = 16'h0, pc_out, r = 16'h16, w, t, pc, ex;
  logic [4:0] tested_register_field_out;
  logic [7:0] reg_data_in = 8'h0;
  logic [1:0] index_register_operand_out;
  logic [3:0] flags_in = 4'h0, bank_sel_in = 4'h0;
  logic push_out, flags_write_out;
  lbc_pkg::lbc_frame_t push_frame_out;
  int errors = 0, check_count = 0, k;
  always #5 clock_in = ~clock_in;
  lbc_prog_mem mem (.addr_in(fetch_addr_out), .word_out(instr_word_in));
  lbc_unit DUT (.*);
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    pc = 16'h0;
    for (k = 0; k < 60; k++) begin
      r = nx(r);
      t = nx(r);
      r = nx(t);
      ex = pc + 16'h1;
      case (k % 6)
        0, 1: begin w = {15'h4400, k[0]}; ex = t; end
        2, 3: begin w = {7'h26, r[8:0]}; ex = (r[8 + r[7:5]] == r[8]) ? t : pc + 16'h2; end
        4: begin w = {14'h2201, r[1:0]}; ex = ~t; end
        default: w = 16'h0;
      endcase
      mem.mem[pc] = w;
      mem.mem[pc + 16'h1] = t;
      @(posedge clock_in);
      instr_valid_in <= 1'b1;
      reg_data_in <= r[15:8];
      index_data_in <= ~t;
      flags_in <= r[3:0];
      bank_sel_in <= r[7:4];
      global_interrupt_enable_in <= r[9];
      @(posedge clock_in);
      instr_valid_in <= (k % 6 < 4);
      #1;
      `CHK("push", k % 6 == 0, push_out)
      if (push_out === 1'b1) `CHK("frame", {pc + 16'h2, r[3:0], r[9], r[7:4]}, push_frame_out)
      if (k % 6 < 4) begin
        @(posedge clock_in);
        instr_valid_in <= 1'b0;
        #1;
      end
      `CHK("pc", ex, pc_out)
      `CHK("flagw", 1'b0, flags_write_out)
      pc = ex;
    end
    $display("program test done");
    report_and_stop();
  end
endmodule // tb_top

// >>> rtl/lbc_bit_select.sv
// picks one bit of the tested register
`timescale 1ns/100ps
`include "lbc_defs.svh"
module lbc_bit_select #(
  parameter int WIDTH = `LBC_DATA_W
) (
  input wire logic [WIDTH-1:0] value_in,
  input wire logic [2:0] position_in,
  output logic bit_out
);
  assign bit_out = value_in[position_in];
endmodule // lbc_bit_select

// >>> rtl/lbc_defs.svh
// constants for the long branch and call unit
`ifndef LBC_DEFS_SVH
`define LBC_DEFS_SVH
`define LBC_PC_W 16
`define LBC_DATA_W 8
`define LBC_REG_SEL_W 5
`define LBC_IDX_SEL_W 2
`define LBC_FLAGS_W 4
`define LBC_BANK_W 4
`define LBC_OP_CLASS_HI 15
`define LBC_OP_CLASS_LO 9
`define LBC_COND_JUMP_CLASS 7'h26
`define LBC_LONG_CALL_WORD 16'h8800
`define LBC_JUMP_ABS_WORD 16'h8801
`define LBC_JUMP_IDX_HI 15
`define LBC_JUMP_IDX_LO 2
`define LBC_JUMP_IDX_CLASS 14'h2201
`define LBC_SENSE_BIT 8
`define LBC_POS_HI 7
`define LBC_POS_LO 5
`define LBC_RS_HI 4
`define LBC_RS_LO 0
`define LBC_IDX_HI 1
`define LBC_IDX_LO 0
`define LBC_PC_RESET 16'h0000
`define LBC_PC_STEP 16'h0001
`define LBC_RET_STEP 16'h0002
`endif

// >>> rtl/lbc_pkg.sv
// types for the long branch and call unit
package lbc_pkg;
  typedef enum logic [1:0] {
    LBC_OP_NONE, LBC_OP_CALL, LBC_OP_JCOND, LBC_OP_JABS
  } lbc_op_t;
  typedef struct packed {
    logic [15:0] pc;
    logic [3:0] flags;
    logic global_interrupt_enable;
    logic [3:0] bank_sel;
  } lbc_frame_t;
endpackage

// >>> rtl/lbc_unit.sv
// long call and long jump execution unit
// Behaviour
// - call pushes pc, flags, enable, banks first
// - call target is full sixteen bit address
// - conditional jump only when bit matches sense
// - bit position zero is lsb, seven msb
// - tested register is any active register
// - jump target from operand or index register
// - jump reaches whole instruction space
`timescale 1ns/100ps
`include "lbc_defs.svh"
module lbc_unit (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire logic [15:0] instr_word_in,
  output logic [15:0] fetch_addr_out,
  output logic [4:0] tested_register_field_out,
  input wire logic [7:0] reg_data_in,
  output logic [1:0] index_register_operand_out,
  input wire logic [15:0] index_data_in,
  input wire logic [3:0] flags_in,
  input wire logic global_interrupt_enable_in,
  input wire logic [3:0] bank_sel_in,
  output logic push_out,
  output lbc_pkg::lbc_frame_t push_frame_out,
  output logic [15:0] pc_out,
  output logic flags_write_out
);
  typedef enum logic [1:0] {LBC_ST_FETCH, LBC_ST_OPERAND} lbc_state_t;
  lbc_state_t state_q;
  lbc_pkg::lbc_op_t op_q;
  logic [15:0] pc_q;
  logic sense_q;
  logic bit_hit_q;
  logic push_q;
  lbc_pkg::lbc_frame_t frame_q;
  logic selected_bit;
  logic is_cond;
  logic is_call;
  logic is_jabs;
  logic is_jidx;
  logic [15:0] next_word_pc;
  function automatic logic is_class(input logic [15:0] w);
    return w[`LBC_OP_CLASS_HI:`LBC_OP_CLASS_LO] == `LBC_COND_JUMP_CLASS;
  endfunction
  assign is_cond = is_class(instr_word_in);
  assign is_call = instr_word_in == `LBC_LONG_CALL_WORD;
  assign is_jabs = instr_word_in == `LBC_JUMP_ABS_WORD;
  assign is_jidx = instr_word_in[`LBC_JUMP_IDX_HI:`LBC_JUMP_IDX_LO] == `LBC_JUMP_IDX_CLASS;
  assign next_word_pc = pc_q + `LBC_PC_STEP;
  assign tested_register_field_out = instr_word_in[`LBC_RS_HI:`LBC_RS_LO];
  assign index_register_operand_out = instr_word_in[`LBC_IDX_HI:`LBC_IDX_LO];
  lbc_bit_select #(.WIDTH(`LBC_DATA_W)) u_bit (
    .value_in(reg_data_in),
    .position_in(instr_word_in[`LBC_POS_HI:`LBC_POS_LO]),
    .bit_out(selected_bit)
  );
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= LBC_ST_FETCH;
      op_q <= lbc_pkg::LBC_OP_NONE;
      sense_q <= 1'b0;
      bit_hit_q <= 1'b0;
    end else if (instr_valid_in) begin
      unique case (state_q)
        LBC_ST_FETCH: begin
          if (is_cond) begin
            op_q <= lbc_pkg::LBC_OP_JCOND;
            sense_q <= instr_word_in[`LBC_SENSE_BIT];
            bit_hit_q <= selected_bit;
            state_q <= LBC_ST_OPERAND;
          end else if (is_call) begin
            op_q <= lbc_pkg::LBC_OP_CALL;
            state_q <= LBC_ST_OPERAND;
          end else if (is_jabs) begin
            op_q <= lbc_pkg::LBC_OP_JABS;
            state_q <= LBC_ST_OPERAND;
          end else begin
            op_q <= lbc_pkg::LBC_OP_NONE;
          end
        end
        LBC_ST_OPERAND: begin
          op_q <= lbc_pkg::LBC_OP_NONE;
          state_q <= LBC_ST_FETCH;
        end
        default: state_q <= LBC_ST_FETCH;
      endcase
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_q <= `LBC_PC_RESET;
    end else if (instr_valid_in) begin
      if (state_q == LBC_ST_FETCH && is_jidx && !is_cond && !is_call && !is_jabs) begin
        pc_q <= index_data_in;
      end else if (state_q == LBC_ST_OPERAND) begin
        unique case (op_q)
          lbc_pkg::LBC_OP_CALL: pc_q <= instr_word_in;
          lbc_pkg::LBC_OP_JABS: pc_q <= instr_word_in;
          lbc_pkg::LBC_OP_JCOND: begin
            if (bit_hit_q == sense_q) begin
              pc_q <= instr_word_in;
            end else begin
              pc_q <= next_word_pc;
            end
          end
          default: pc_q <= next_word_pc;
        endcase
      end else begin
        pc_q <= next_word_pc;
      end
    end
  end
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      push_q <= 1'b0;
      frame_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (instr_valid_in && state_q == LBC_ST_FETCH && is_call) begin
        push_q <= 1'b1;
        frame_q.pc <= pc_q + `LBC_RET_STEP;
        frame_q.flags <= flags_in;
        frame_q.global_interrupt_enable <= global_interrupt_enable_in;
        frame_q.bank_sel <= bank_sel_in;
      end
    end
  end
  assign fetch_addr_out = pc_q;
  assign pc_out = pc_q;
  assign push_out = push_q;
  assign push_frame_out = frame_q;
  assign flags_write_out = 1'b0;
endmodule // lbc_unit
